//--- hdl/lcm_cell.sv
// lookup table logic cell with one register, chains and bus emulation
// How it works
// - four modes route inputs differently
// - six logic inputs plus clock, clear, preset
// - sync clock enable, first data input gates
// - normal table: carry-in or third data selectable
// - table output joins cascade chain
// - fourth data input can feed register directly
// - packed register keeps controls, outputs swap
// - arithmetic: sum table and carry table
// - cascade usable alongside carry in arithmetic
// - up/down counter: enable, direction, load mux
// - counters loadable through clear and preset
// - clearable counter ANDs load mux with clear
// - bus emulation: contention low, floating high
// - clear from either group control line
// - first group line loads third data input
// - clear and preset active low, idle high
// - six clear and preset schemes
// - chip reset overrides all, may preset
// - preset by tied-high load or inverted clear
// - first line presets, second line clears
// - load via first line, second only clears
// - second line presets by inverted clear
// - D, T, JK, SR or bypassed register
`timescale 1ns/10ps
`include "lcm_params.svh"
module lcm_cell (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CHIP_RESET_N,
    input wire logic GROUP_CONTROL_FIRST_N,
    input wire logic GROUP_CONTROL_SECOND_N,
    input wire logic GROUP_CLOCK,
    input wire logic SYNC_ENABLE_INPUT,
    input wire logic DATA_SECOND,
    input wire logic ASYNC_LOAD_VALUE_INPUT,
    input wire logic DIRECT_REGISTER_INPUT,
    input wire logic CARRY_IN,
    input wire logic CASCADE_IN,
    input wire logic [`LCM_TRI_N-1:0] TRI_DATA,
    input wire logic [`LCM_TRI_N-1:0] TRI_OE,
    input wire lcm_pkg::lcm_mode_e MODE,
    input wire logic [`LCM_LUT_W-1:0] LUT_MASK,
    input wire logic LUT_USE_CARRY,
    input wire logic CE_FROM_DATA,
    input wire logic CLOCK_FROM_GROUP,
    input wire logic PACK_EN,
    input wire logic PACK_LOCAL_REG,
    input wire logic CASCADE_EN,
    input wire logic CASCADE_OR,
    input wire lcm_pkg::lcm_ff_e FF_TYPE,
    input wire lcm_pkg::lcm_scheme_e CLR_SCHEME,
    input wire logic CLEAR_FROM_SECOND,
    input wire logic PRESET_BY_INVERT,
    input wire logic RESET_PRESETS,
    output logic LOCAL_OUT,
    output logic ROUTE_OUT,
    output logic CARRY_OUT,
    output logic CASCADE_OUT,
    output logic TRI_BUS_OUT,
    output logic REG_STATE
);
    // pin-side lines: chip reset, two group lines, group clock
    logic [`LCM_SYNC_N-1:0] sync_raw;
    logic [`LCM_SYNC_N-1:0] sync_s1_r;
    logic [`LCM_SYNC_N-1:0] sync_s2_r;
    // active-low lines idle high so nothing fires out of reset
    localparam logic [`LCM_SYNC_N-1:0] sync_idle = 4'h7;
    logic chip_rst_n;
    logic ctl1_n;
    logic ctl2_n;
    logic gclk_s;
    logic gclk_prev_r;
    logic gclk_pulse;
    logic [`LCM_LUT_IDX_W-1:0] lut_idx;
    logic lut4;
    logic lut_lo;
    logic lut_hi;
    logic clr_n;
    logic pre_n;
    logic inv;
    logic stored_r;
    logic stored_nxt;
    logic vis;
    logic vis_nxt;
    logic func;
    logic carry_nxt;
    logic casc_nxt;
    logic din;
    logic ff_nxt;
    logic ce;
    logic cnt_up;
    logic cnt_data;
    logic cnt_mux;
    logic cnt_d;
    logic cnt_carry;
    logic comb_val;
    logic reg_val;
    logic local_nxt;
    logic route_nxt;
    logic [`LCM_TRI_N-1:0] tri_drive;
    logic tri_multi;
    logic tri_none;
    logic tri_nxt;
    logic local_r;
    logic route_r;
    logic carry_r;
    logic casc_r;
    logic tri_r;
    logic state_r;

    assign sync_raw = {GROUP_CLOCK, GROUP_CONTROL_SECOND_N, GROUP_CONTROL_FIRST_N, CHIP_RESET_N};

    genvar gi;
    generate
        for (gi = 0; gi < `LCM_SYNC_N; gi = gi + 1) begin : g_sync
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    sync_s1_r[gi] <= sync_idle[gi];
                    sync_s2_r[gi] <= sync_idle[gi];
                end else begin
                    sync_s1_r[gi] <= sync_raw[gi];
                    sync_s2_r[gi] <= sync_s1_r[gi];
                end
            end
        end
    endgenerate

    assign chip_rst_n = sync_s2_r[0];
    assign ctl1_n = sync_s2_r[1];
    assign ctl2_n = sync_s2_r[2];
    assign gclk_s = sync_s2_r[3];

    // group clock becomes an enable pulse on its rising edge
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            gclk_prev_r <= 1'b0;
        end else begin
            gclk_prev_r <= gclk_s;
        end
    end
    assign gclk_pulse = gclk_s & ~gclk_prev_r;

    // table index differs per mode
    always_comb begin
        if (MODE == lcm_pkg::LCM_NORMAL) begin
            lut_idx = {DIRECT_REGISTER_INPUT,
                       LUT_USE_CARRY ? CARRY_IN : ASYNC_LOAD_VALUE_INPUT,
                       DATA_SECOND, SYNC_ENABLE_INPUT};
        end else begin
            lut_idx = {1'b0, CARRY_IN, DATA_SECOND, SYNC_ENABLE_INPUT};
        end
    end

    lcm_lut u_lut (
        .mask(LUT_MASK),
        .idx(lut_idx),
        .out4(lut4),
        .out_lo(lut_lo),
        .out_hi(lut_hi)
    );

    lcm_clrpre u_clrpre (
        .scheme(CLR_SCHEME),
        .clear_from_second(CLEAR_FROM_SECOND),
        .preset_by_invert(PRESET_BY_INVERT),
        .ctl1_n(ctl1_n),
        .ctl2_n(ctl2_n),
        .load_value(ASYNC_LOAD_VALUE_INPUT),
        .clr_n(clr_n),
        .pre_n(pre_n),
        .invert(inv)
    );

    assign vis = stored_r ^ inv;

    // counter bit: enable on second data, load select on third
    always_comb begin
        cnt_up = (MODE == lcm_pkg::LCM_UPDN) ? CASCADE_IN : 1'b1;
        cnt_data = vis ^ (DATA_SECOND & CARRY_IN);
        cnt_mux = ASYNC_LOAD_VALUE_INPUT ? DIRECT_REGISTER_INPUT : cnt_data;
        if (MODE == lcm_pkg::LCM_CLRCNT) begin
            cnt_d = cnt_mux & CASCADE_IN;
        end else begin
            cnt_d = cnt_mux;
        end
        cnt_carry = CARRY_IN & (cnt_up ? vis : ~vis);
    end

    // per-mode function, carry and cascade results
    always_comb begin
        case (MODE)
            lcm_pkg::LCM_NORMAL: begin
                func = lut4;
                carry_nxt = 1'b0;
            end
            lcm_pkg::LCM_ARITH: begin
                func = lut_lo;
                carry_nxt = lut_hi;
            end
            lcm_pkg::LCM_UPDN, lcm_pkg::LCM_CLRCNT: begin
                func = cnt_d;
                carry_nxt = cnt_carry;
            end
            default: begin
                func = lut4;
                carry_nxt = 1'b0;
            end
        endcase
        // cascade joins normal and arithmetic; counters use cascade-in
        if (CASCADE_EN && (MODE == lcm_pkg::LCM_NORMAL || MODE == lcm_pkg::LCM_ARITH)) begin
            casc_nxt = CASCADE_OR ? (func | CASCADE_IN) : (func & CASCADE_IN);
        end else begin
            casc_nxt = func;
        end
    end

    // register data and flip-flop type
    always_comb begin
        if (PACK_EN && MODE == lcm_pkg::LCM_NORMAL) begin
            din = DIRECT_REGISTER_INPUT;
        end else begin
            din = func;
        end
        case (FF_TYPE)
            lcm_pkg::LCM_FF_D: ff_nxt = din;
            lcm_pkg::LCM_FF_T: ff_nxt = vis ^ din;
            lcm_pkg::LCM_FF_JK: ff_nxt = (din & ~vis) | (~DATA_SECOND & vis);
            lcm_pkg::LCM_FF_SR: ff_nxt = DATA_SECOND ? 1'b0 : (din | vis);
            lcm_pkg::LCM_FF_BYPASS: ff_nxt = vis;
            default: ff_nxt = din;
        endcase
        ce = (CE_FROM_DATA ? SYNC_ENABLE_INPUT : 1'b1) &
             (CLOCK_FROM_GROUP ? gclk_pulse : 1'b1);
    end

    // priority: chip reset, clear, preset, clocked load
    always_comb begin
        if (!chip_rst_n) begin
            stored_nxt = RESET_PRESETS ^ inv;
        end else if (!clr_n) begin
            stored_nxt = 1'b0;
        end else if (!pre_n) begin
            stored_nxt = 1'b1;
        end else if (ce) begin
            stored_nxt = ff_nxt ^ inv;
        end else begin
            stored_nxt = stored_r;
        end
        vis_nxt = stored_nxt ^ inv;
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stored_r <= 1'b0;
        end else begin
            stored_r <= stored_nxt;
        end
    end

    // output selection; comb path is retimed by one cycle
    always_comb begin
        comb_val = func;
        reg_val = vis_nxt;
        if (PACK_EN) begin
            local_nxt = PACK_LOCAL_REG ? reg_val : comb_val;
            route_nxt = PACK_LOCAL_REG ? comb_val : reg_val;
        end else if (FF_TYPE == lcm_pkg::LCM_FF_BYPASS) begin
            local_nxt = comb_val;
            route_nxt = comb_val;
        end else begin
            local_nxt = reg_val;
            route_nxt = reg_val;
        end
    end

    // bus emulation: no tristate, contention cannot reach a wire
    generate
        for (gi = 0; gi < `LCM_TRI_N; gi = gi + 1) begin : g_tri
            assign tri_drive[gi] = TRI_OE[gi] & TRI_DATA[gi];
        end
    endgenerate
    assign tri_multi = |(TRI_OE & (TRI_OE - `LCM_TRI_N'(1)));
    assign tri_none = ~|TRI_OE;
    always_comb begin
        if (tri_none) begin
            tri_nxt = 1'b1;
        end else if (tri_multi) begin
            tri_nxt = 1'b0;
        end else begin
            tri_nxt = |tri_drive;
        end
    end

    // registered outputs; chains gain a cycle of latency per cell
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            local_r <= 1'b0;
            route_r <= 1'b0;
            state_r <= 1'b0;
        end else begin
            local_r <= local_nxt;
            route_r <= route_nxt;
            state_r <= vis_nxt;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            carry_r <= 1'b0;
            casc_r <= 1'b0;
        end else begin
            carry_r <= carry_nxt;
            casc_r <= casc_nxt;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tri_r <= 1'b1;
        end else begin
            tri_r <= tri_nxt;
        end
    end

    assign LOCAL_OUT = local_r;
    assign ROUTE_OUT = route_r;
    assign CARRY_OUT = carry_r;
    assign CASCADE_OUT = casc_r;
    assign TRI_BUS_OUT = tri_r;
    assign REG_STATE = state_r;
endmodule

//--- hdl/lcm_clrpre.sv
// clear and preset scheme decode for the cell register
`timescale 1ns/10ps
module lcm_clrpre (
    input wire lcm_pkg::lcm_scheme_e scheme,
    input wire logic clear_from_second,
    input wire logic preset_by_invert,
    input wire logic ctl1_n,
    input wire logic ctl2_n,
    input wire logic load_value,
    output logic clr_n,
    output logic pre_n,
    output logic invert
);
    logic ld;
    assign ld = ~ctl1_n;
    always_comb begin
        clr_n = 1'b1;
        pre_n = 1'b1;
        invert = 1'b0;
        case (scheme)
            lcm_pkg::LCM_SCH_CLR: begin
                clr_n = clear_from_second ? ctl2_n : ctl1_n;
            end
            lcm_pkg::LCM_SCH_PRE: begin
                if (preset_by_invert) begin
                    invert = 1'b1;
                    clr_n = ctl1_n;
                end else begin
                    pre_n = ctl1_n;
                end
            end
            lcm_pkg::LCM_SCH_CLRPRE: begin
                pre_n = ctl1_n;
                clr_n = ctl2_n;
            end
            lcm_pkg::LCM_SCH_LDCLR: begin
                pre_n = ~(ld & load_value);
                clr_n = ~(ld & ~load_value) & ctl2_n;
            end
            lcm_pkg::LCM_SCH_LDPRE: begin
                // stored bit is inverted, so the loaded value is too
                invert = 1'b1;
                pre_n = ~(ld & ~load_value);
                clr_n = ~(ld & load_value) & ctl2_n;
            end
            lcm_pkg::LCM_SCH_LD: begin
                pre_n = ~(ld & load_value);
                clr_n = ~(ld & ~load_value);
            end
            default: begin
                clr_n = 1'b1;
            end
        endcase
    end
endmodule

//--- hdl/lcm_lut.sv
// four-input lookup table, also read as two three-input halves
`timescale 1ns/10ps
`include "lcm_params.svh"
module lcm_lut (
    input wire logic [`LCM_LUT_W-1:0] mask,
    input wire logic [`LCM_LUT_IDX_W-1:0] idx,
    output logic out4,
    output logic out_lo,
    output logic out_hi
);
    // low half gives sum, high half gives carry in arithmetic use
    always_comb begin
        out4 = mask[idx];
        out_lo = mask[{1'b0, idx[2:0]}];
        out_hi = mask[{1'b1, idx[2:0]}];
    end
endmodule

//--- hdl/lcm_params.svh
// constants for the lookup table logic cell
`ifndef LCM_PARAMS_SVH
`define LCM_PARAMS_SVH
`define LCM_MODE_W 2
`define LCM_MODE_NORMAL 2'h0
`define LCM_MODE_ARITH 2'h1
`define LCM_MODE_UPDN 2'h2
`define LCM_MODE_CLRCNT 2'h3
`define LCM_FF_W 3
`define LCM_FF_D 3'h0
`define LCM_FF_T 3'h1
`define LCM_FF_JK 3'h2
`define LCM_FF_SR 3'h3
`define LCM_FF_BYPASS 3'h4
`define LCM_SCH_W 3
`define LCM_SCH_CLR 3'h0
`define LCM_SCH_PRE 3'h1
`define LCM_SCH_CLRPRE 3'h2
`define LCM_SCH_LDCLR 3'h3
`define LCM_SCH_LDPRE 3'h4
`define LCM_SCH_LD 3'h5
`define LCM_LUT_W 16
`define LCM_LUT_IDX_W 4
`define LCM_TRI_N 4
`define LCM_SYNC_N 4
`endif

//--- hdl/lcm_pkg.sv
// types shared by the logic cell modules
package lcm_pkg;
`include "lcm_params.svh"
    typedef enum logic [`LCM_MODE_W-1:0] {
        LCM_NORMAL = `LCM_MODE_NORMAL,
        LCM_ARITH = `LCM_MODE_ARITH,
        LCM_UPDN = `LCM_MODE_UPDN,
        LCM_CLRCNT = `LCM_MODE_CLRCNT
    } lcm_mode_e;
    typedef enum logic [`LCM_FF_W-1:0] {
        LCM_FF_D = `LCM_FF_D,
        LCM_FF_T = `LCM_FF_T,
        LCM_FF_JK = `LCM_FF_JK,
        LCM_FF_SR = `LCM_FF_SR,
        LCM_FF_BYPASS = `LCM_FF_BYPASS
    } lcm_ff_e;
    typedef enum logic [`LCM_SCH_W-1:0] {
        LCM_SCH_CLR = `LCM_SCH_CLR,
        LCM_SCH_PRE = `LCM_SCH_PRE,
        LCM_SCH_CLRPRE = `LCM_SCH_CLRPRE,
        LCM_SCH_LDCLR = `LCM_SCH_LDCLR,
        LCM_SCH_LDPRE = `LCM_SCH_LDPRE,
        LCM_SCH_LD = `LCM_SCH_LD
    } lcm_scheme_e;
endpackage

//--- tb/lcm_cell_properties.sv
// port-level checker for the logic cell
`timescale 1ns/10ps
module lcm_cell_properties (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CHIP_RESET_N,
    input wire logic GROUP_CONTROL_FIRST_N,
    input wire logic GROUP_CONTROL_SECOND_N,
    input wire logic SYNC_ENABLE_INPUT,
    input wire logic DATA_SECOND,
    input wire logic ASYNC_LOAD_VALUE_INPUT,
    input wire logic DIRECT_REGISTER_INPUT,
    input wire logic CARRY_IN,
    input wire logic CASCADE_IN,
    input wire logic [3:0] TRI_DATA,
    input wire logic [3:0] TRI_OE,
    input wire lcm_pkg::lcm_mode_e MODE,
    input wire logic [15:0] LUT_MASK,
    input wire logic LUT_USE_CARRY,
    input wire logic CE_FROM_DATA,
    input wire logic CLOCK_FROM_GROUP,
    input wire logic PACK_EN,
    input wire logic CASCADE_EN,
    input wire logic CASCADE_OR,
    input wire lcm_pkg::lcm_ff_e FF_TYPE,
    input wire lcm_pkg::lcm_scheme_e CLR_SCHEME,
    input wire logic PRESET_BY_INVERT,
    input wire logic RESET_PRESETS,
    input wire logic CARRY_OUT,
    input wire logic CASCADE_OUT,
    input wire logic TRI_BUS_OUT,
    input wire logic REG_STATE
);
    logic [3:0] nix;
    logic lut_n, casc_and, ar_c, tri_any, nd;
    assign nix = {DIRECT_REGISTER_INPUT, LUT_USE_CARRY ? CARRY_IN : ASYNC_LOAD_VALUE_INPUT,
        DATA_SECOND, SYNC_ENABLE_INPUT};
    assign lut_n = LUT_MASK[nix];
    assign casc_and = lut_n & CASCADE_IN;
    assign ar_c = LUT_MASK[{1'h1, CARRY_IN, DATA_SECOND, SYNC_ENABLE_INPUT}];
    assign tri_any = |(TRI_DATA & TRI_OE);
    assign nd = MODE == lcm_pkg::LCM_NORMAL && FF_TYPE == lcm_pkg::LCM_FF_D && !PACK_EN
        && !CLOCK_FROM_GROUP && (!CE_FROM_DATA || SYNC_ENABLE_INPUT);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // pin lines pass two sync flops, so every line rule spans three edges
    sequence idle3;
        (CHIP_RESET_N && GROUP_CONTROL_FIRST_N && GROUP_CONTROL_SECOND_N)[*3];
    endsequence
    AST_TRI_NONE: assert property (TRI_OE == 4'h0 |=> TRI_BUS_OUT)
        else $error("floating bus not high");
    AST_TRI_MULTI: assert property ($countones(TRI_OE) > 1 |=> !TRI_BUS_OUT)
        else $error("contending bus not low");
    AST_TRI_ONE: assert property ($onehot(TRI_OE) |=> TRI_BUS_OUT == $past(tri_any))
        else $error("single driver not passed");
    AST_CHIP: assert property ((!CHIP_RESET_N)[*3] |=> REG_STATE == $past(RESET_PRESETS))
        else $error("chip reset not applied");
    AST_CLR2: assert property ((CHIP_RESET_N && !GROUP_CONTROL_SECOND_N
        && CLR_SCHEME == lcm_pkg::LCM_SCH_CLRPRE)[*3] |=> !REG_STATE)
        else $error("second line did not clear");
    AST_PRE1: assert property ((CHIP_RESET_N && !GROUP_CONTROL_FIRST_N
        && GROUP_CONTROL_SECOND_N && CLR_SCHEME == lcm_pkg::LCM_SCH_CLRPRE)[*3] |=> REG_STATE)
        else $error("first line did not preset");
    AST_LOAD: assert property ((CHIP_RESET_N && !GROUP_CONTROL_FIRST_N
        && CLR_SCHEME == lcm_pkg::LCM_SCH_LD && $stable(ASYNC_LOAD_VALUE_INPUT))[*3]
        |=> REG_STATE == $past(ASYNC_LOAD_VALUE_INPUT))
        else $error("async load value not taken");
    // inversion change flips the visible bit, so it must stand still too
    AST_CE_HOLD: assert property (idle3 ##0 (CE_FROM_DATA && !SYNC_ENABLE_INPUT
        && $stable(CLR_SCHEME) && $stable(PRESET_BY_INVERT)) |=> $stable(REG_STATE))
        else $error("register moved with enable low");
    AST_NORM_D: assert property (idle3 ##0 nd |=> REG_STATE == $past(lut_n))
        else $error("table value not registered");
    AST_CASC: assert property (MODE == lcm_pkg::LCM_NORMAL && CASCADE_EN && !CASCADE_OR
        |=> CASCADE_OUT == $past(casc_and))
        else $error("cascade and wrong");
    AST_ARITH: assert property (MODE == lcm_pkg::LCM_ARITH |=> CARRY_OUT == $past(ar_c))
        else $error("carry table wrong");
    COV_UPDN: cover property (MODE == lcm_pkg::LCM_UPDN ##1 MODE == lcm_pkg::LCM_UPDN);
    COV_CHIP: cover property ((!CHIP_RESET_N)[*3]);
    COV_MULTI: cover property ($countones(TRI_OE) > 2);
endmodule
bind lcm_cell lcm_cell_properties lcm_cell_properties_inst (.*);

//--- tb/lcm_cell_test.sv
// self-checking bench for the logic cell
`timescale 1ns/10ps
`include "lcm_params.svh"
module lcm_cell_test;
    logic CLK, ARST_N, CHIP_RESET_N, GROUP_CONTROL_FIRST_N, GROUP_CONTROL_SECOND_N;
    logic GROUP_CLOCK, SYNC_ENABLE_INPUT, DATA_SECOND, ASYNC_LOAD_VALUE_INPUT;
    logic DIRECT_REGISTER_INPUT, LUT_USE_CARRY, CE_FROM_DATA, CLOCK_FROM_GROUP, PACK_EN;
    logic PACK_LOCAL_REG, CASCADE_EN, CASCADE_OR, CLEAR_FROM_SECOND, PRESET_BY_INVERT;
    logic RESET_PRESETS, LOCAL_OUT, ROUTE_OUT, CARRY_OUT, CASCADE_OUT, TRI_BUS_OUT, REG_STATE;
    wire logic CARRY_IN, CASCADE_IN;
    logic [`LCM_TRI_N-1:0] TRI_DATA, TRI_OE;
    logic [`LCM_LUT_W-1:0] LUT_MASK, lf;
    logic [1:0] nbr_nxt;
    logic [4:0] e;
    logic q, t;
    lcm_pkg::lcm_mode_e MODE;
    lcm_pkg::lcm_ff_e FF_TYPE;
    lcm_pkg::lcm_scheme_e CLR_SCHEME;
    int num_errors, cmp_count;
    lcm_cell lcm_cell_inst (.*);
    lcm_nbr lcm_nbr_inst (.clk(CLK), .arst_n(ARST_N), .nxt(nbr_nxt), .carry_q(CARRY_IN),
        .cascade_q(CASCADE_IN));
    initial begin
        CLK = 1'h0;
        forever #5 CLK = ~CLK;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic tri_exp(input logic [3:0] d, input logic [3:0] oe);
        if ($countones(oe) > 1) return 1'h0;
        if (oe == 4'h0) return 1'h1;
        return |(d & oe);
    endfunction
    // returns register, carry, cascade, local, route
    function automatic logic [4:0] exp_step(input logic qo);
        logic [3:0] ix;
        logic l, d, r, c, k;
        ix = {DIRECT_REGISTER_INPUT, LUT_USE_CARRY ? CARRY_IN : ASYNC_LOAD_VALUE_INPUT,
            DATA_SECOND, SYNC_ENABLE_INPUT};
        if (MODE == lcm_pkg::LCM_ARITH) ix = {1'h0, CARRY_IN, DATA_SECOND, SYNC_ENABLE_INPUT};
        l = LUT_MASK[ix];
        d = PACK_EN ? DIRECT_REGISTER_INPUT : l;
        case (FF_TYPE)
            lcm_pkg::LCM_FF_T: r = qo ^ d;
            lcm_pkg::LCM_FF_JK: r = (d & ~qo) | (~DATA_SECOND & qo);
            lcm_pkg::LCM_FF_SR: r = DATA_SECOND ? 1'h0 : (d | qo);
            lcm_pkg::LCM_FF_BYPASS: r = qo;
            default: r = d;
        endcase
        c = (MODE == lcm_pkg::LCM_ARITH) ? LUT_MASK[ix + 4'h8] : 1'h0;
        if (MODE >= lcm_pkg::LCM_UPDN) begin
            c = ((MODE == lcm_pkg::LCM_CLRCNT || CASCADE_IN) ? qo : ~qo) & CARRY_IN;
        end
        if (MODE >= lcm_pkg::LCM_UPDN) begin
            r = ASYNC_LOAD_VALUE_INPUT ? DIRECT_REGISTER_INPUT : qo ^ (DATA_SECOND & CARRY_IN);
        end
        if (MODE == lcm_pkg::LCM_CLRCNT && !CASCADE_IN) r = 1'h0;
        if (CE_FROM_DATA && !SYNC_ENABLE_INPUT) r = qo;
        k = CASCADE_OR ? l | CASCADE_IN : l & CASCADE_IN;
        if (PACK_EN) return {r, c, k, PACK_LOCAL_REG ? {r, l} : {l, r}};
        if (FF_TYPE == lcm_pkg::LCM_FF_BYPASS) return {r, c, k, l, l};
        return {r, c, k, r, r};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge CLK);
    endtask
    task automatic chk(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t mismatch got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic rst();
        ARST_N = 1'h0;
        q = 1'h0;
        tick(20);
        chk(TRI_BUS_OUT, 1'h1);
        chk(REG_STATE, 1'h0);
        ARST_N = 1'h1;
        tick(3);
    endtask
    task automatic sch(input lcm_pkg::lcm_scheme_e s, input logic [6:0] v);
        CLR_SCHEME = s;
        {ASYNC_LOAD_VALUE_INPUT, CLEAR_FROM_SECOND, RESET_PRESETS} = v[4:2];
        tick(1);
        {GROUP_CONTROL_FIRST_N, GROUP_CONTROL_SECOND_N, CHIP_RESET_N} = {v[6:5], v[1]};
        tick(3);
        chk(REG_STATE, v[0]);
        // unused active-low lines go back to idle high
        {GROUP_CONTROL_FIRST_N, GROUP_CONTROL_SECOND_N, CHIP_RESET_N} = 3'h7;
        tick(3);
    endtask
    initial begin
        {ARST_N, CHIP_RESET_N, GROUP_CONTROL_FIRST_N, GROUP_CONTROL_SECOND_N} = 4'h7;
        {GROUP_CLOCK, SYNC_ENABLE_INPUT, DATA_SECOND, ASYNC_LOAD_VALUE_INPUT} = 4'h0;
        {DIRECT_REGISTER_INPUT, LUT_USE_CARRY, CE_FROM_DATA, CLOCK_FROM_GROUP} = 4'h0;
        {PACK_EN, PACK_LOCAL_REG, CASCADE_EN, CASCADE_OR, CLEAR_FROM_SECOND} = 5'h0;
        {PRESET_BY_INVERT, RESET_PRESETS, nbr_nxt, TRI_DATA, TRI_OE} = 12'h0;
        MODE = lcm_pkg::LCM_NORMAL;
        FF_TYPE = lcm_pkg::LCM_FF_D;
        CLR_SCHEME = lcm_pkg::LCM_SCH_CLR;
        LUT_MASK = 16'h0;
        lf = 16'h91da;
        num_errors = 0;
        cmp_count = 0;
        rst();
        for (int i = 0; i < 400; i++) begin
            lf = lfsr(lf);
            LUT_MASK = lf;
            lf = lfsr(lf);
            MODE = lcm_pkg::lcm_mode_e'(2'(i / 100));
            FF_TYPE = (i >= 100) ? lcm_pkg::LCM_FF_D : lf[13] ? lcm_pkg::LCM_FF_BYPASS :
                lcm_pkg::lcm_ff_e'({1'h0, lf[9:8]});
            PACK_EN = (i < 100) && lf[14];
            PACK_LOCAL_REG = lf[15];
            {SYNC_ENABLE_INPUT, DATA_SECOND, ASYNC_LOAD_VALUE_INPUT, DIRECT_REGISTER_INPUT} = lf[3:0];
            {LUT_USE_CARRY, CE_FROM_DATA, CASCADE_EN, CASCADE_OR} = lf[7:4];
            {TRI_DATA, TRI_OE} = lf[15:8];
            nbr_nxt = lf[11:10] ^ lf[1:0];
            e = exp_step(q);
            t = tri_exp(TRI_DATA, TRI_OE);
            tick(1);
            q = e[4];
            chk(REG_STATE, q);
            chk(TRI_BUS_OUT, t);
            chk(CARRY_OUT, e[3]);
            if (MODE <= lcm_pkg::LCM_ARITH && CASCADE_EN) chk(CASCADE_OUT, e[2]);
            chk(LOCAL_OUT, e[1]);
            chk(ROUTE_OUT, e[0]);
        end
        // a second reset in mid-run, then the clear and preset schemes
        rst();
        MODE = lcm_pkg::LCM_NORMAL;
        FF_TYPE = lcm_pkg::LCM_FF_D;
        PACK_EN = 1'h0;
        // group clock gating: nothing loads until its synced rising edge
        CLOCK_FROM_GROUP = 1'h1;
        LUT_MASK = 16'haaaa;
        {CE_FROM_DATA, SYNC_ENABLE_INPUT} = 2'h1;
        tick(3);
        chk(REG_STATE, 1'h0);
        GROUP_CLOCK = 1'h1;
        tick(3);
        chk(REG_STATE, 1'h1);
        {GROUP_CLOCK, CLOCK_FROM_GROUP} = 2'h0;
        {CE_FROM_DATA, SYNC_ENABLE_INPUT} = 2'h2;
        // fields: first_n, second_n, load value, clear from second, presets, chip_n, result
        sch(lcm_pkg::LCM_SCH_LD, 7'h35);
        sch(lcm_pkg::LCM_SCH_CLR, 7'h32);
        sch(lcm_pkg::LCM_SCH_LD, 7'h35);
        sch(lcm_pkg::LCM_SCH_CLR, 7'h5a);
        sch(lcm_pkg::LCM_SCH_PRE, 7'h33);
        PRESET_BY_INVERT = 1'h1;
        sch(lcm_pkg::LCM_SCH_PRE, 7'h33);
        PRESET_BY_INVERT = 1'h0;
        sch(lcm_pkg::LCM_SCH_CLRPRE, 7'h52);
        sch(lcm_pkg::LCM_SCH_CLRPRE, 7'h33);
        sch(lcm_pkg::LCM_SCH_CLRPRE, 7'h12);
        sch(lcm_pkg::LCM_SCH_LDCLR, 7'h22);
        sch(lcm_pkg::LCM_SCH_LDCLR, 7'h33);
        sch(lcm_pkg::LCM_SCH_LDCLR, 7'h52);
        sch(lcm_pkg::LCM_SCH_LDPRE, 7'h43);
        sch(lcm_pkg::LCM_SCH_LDPRE, 7'h22);
        sch(lcm_pkg::LCM_SCH_LDPRE, 7'h33);
        sch(lcm_pkg::LCM_SCH_LD, 7'h22);
        sch(lcm_pkg::LCM_SCH_LD, 7'h25);
        sch(lcm_pkg::LCM_SCH_LDCLR, 7'h30);
        print_verdict();
    end
    initial begin
        #1000000;
        num_errors++;
        print_verdict();
    end
endmodule

//--- tb/lcm_nbr.sv
// neighbour cell model driving the carry and cascade chains
`timescale 1ns/10ps
module lcm_nbr (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [1:0] nxt,
    output logic carry_q,
    output logic cascade_q
);
    // chain bits leave a neighbour flop, so they move just after the edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {carry_q, cascade_q} <= 2'h0;
        end else begin
            {carry_q, cascade_q} <= nxt;
        end
    end
endmodule
